//--- status_flag_logic.sv
// Purpose: Overflow, parity, user flag and register bank base.
// Assumes: ALU presents operands, result and op with a write-back pulse.
// Notes: All outputs registered; parity trails accumulator by one cycle.
`timescale 1ns/1ps
module status_flag_logic
    import status_flag_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wb_valid,
    input wire alu_op_t wb_op,
    input wire logic [DATA_W-1:0] operand_a,
    input wire logic [DATA_W-1:0] operand_b,
    input wire logic [DATA_W-1:0] sum_result,
    input wire logic [2*DATA_W-1:0] product,
    input wire logic [DATA_W-1:0] accumulator,
    input wire logic sw_write,
    input wire logic sw_user_flag_one,
    input wire logic sw_bank_select_high,
    input wire logic sw_bank_select_low,
    output logic overflow_flag,
    output logic user_flag_one,
    output logic parity_flag,
    output logic bank_select_high,
    output logic bank_select_low,
    output logic [BANK_ADDR_W-1:0] bank_base_addr
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Two's-complement overflow from the three sign bits
    function automatic logic sign_overflow(
        input logic a,
        input logic b,
        input logic r,
        input logic sub
    );
        // Subtract flips the effective sign of the second operand
        sign_overflow = ((a == (b ^ sub)) && (r != a));
    endfunction : sign_overflow

    // Product too large for one byte
    function automatic logic product_too_big(
        input logic [2*DATA_W-1:0] p
    );
        product_too_big = (p > {{DATA_W{1'b0}}, PRODUCT_LIMIT});
    endfunction : product_too_big

    // One when the count of set bits is odd
    function automatic logic odd_parity(
        input logic [DATA_W-1:0] v
    );
        odd_parity = ^v;
    endfunction : odd_parity

    // Bank number times bank size
    function automatic logic [BANK_ADDR_W-1:0] bank_base(
        input logic hi,
        input logic lo
    );
        bank_base = BANK_ADDR_W'({hi, lo}) << BANK_SHIFT;
    endfunction : bank_base

    // ************************************************************
    // Operation decode
    // ************************************************************

    wire logic is_add;
    wire logic is_sub;
    wire logic is_mul;
    wire logic is_div;
    wire logic arith_op;
    wire logic op_taken;

    assign is_add = (wb_op == OP_ADD) || (wb_op == OP_ADD_WITH_CARRY_OP);
    assign is_sub = (wb_op == OP_SUBTRACT_WITH_BORROW_OP);
    assign is_mul = (wb_op == OP_MUL);
    assign is_div = (wb_op == OP_DIV);
    assign arith_op = is_add || is_sub || is_mul || is_div;

    // Only a valid arithmetic write-back may touch the flag
    assign op_taken = wb_valid && arith_op;

    // ************************************************************
    // Overflow conditions
    // ************************************************************

    wire logic a_sign;
    wire logic b_sign;
    wire logic r_sign;
    wire logic add_ovf;
    wire logic mul_ovf;
    wire logic divisor_zero;
    wire logic div_ovf;
    wire logic ovf_hit;

    assign a_sign = operand_a[DATA_W-1];
    assign b_sign = operand_b[DATA_W-1];
    assign r_sign = sum_result[DATA_W-1];

    // Carry-in is already folded into the result by the ALU
    assign add_ovf = (is_add || is_sub) && sign_overflow(a_sign, b_sign, r_sign, is_sub);

    // Full product is compared, not just its upper byte
    assign mul_ovf = is_mul && product_too_big(product);

    assign divisor_zero = (operand_b == '0);
    assign div_ovf = is_div && divisor_zero;

    // Any one condition sets; an arithmetic write-back with none of them clears
    assign ovf_hit = add_ovf || mul_ovf || div_ovf;

    // ************************************************************
    // Next-state values
    // ************************************************************

    logic overflow_r;
    logic overflow_nxt;
    logic parity_r;
    logic parity_nxt;
    logic user_r;
    logic user_nxt;
    logic bsh_r;
    logic bsh_nxt;
    logic bsl_r;
    logic bsl_nxt;
    logic [BANK_ADDR_W-1:0] base_r;
    logic [BANK_ADDR_W-1:0] base_nxt;

    // Non-arithmetic ops leave the flag alone
    assign overflow_nxt = op_taken ? ovf_hit : overflow_r;

    // Registered copy costs one cycle of lag behind the accumulator
    assign parity_nxt = odd_parity(accumulator);

    // Software writes all three fields together
    assign user_nxt = sw_write ? sw_user_flag_one : user_r;
    assign bsh_nxt = sw_write ? sw_bank_select_high : bsh_r;
    assign bsl_nxt = sw_write ? sw_bank_select_low : bsl_r;

    // Base follows the new bank bits in the same write
    assign base_nxt = sw_write ? bank_base(sw_bank_select_high, sw_bank_select_low) : base_r;

    // ************************************************************
    // Overflow flag register
    // ************************************************************

    always_ff @(posedge core_clk) begin
        if (srst) begin
            overflow_r <= RST_OVERFLOW;
        end else begin
            overflow_r <= overflow_nxt;
        end
    end

    // ************************************************************
    // Parity flag register
    // ************************************************************

    always_ff @(posedge core_clk) begin
        if (srst) begin
            parity_r <= RST_PARITY;
        end else begin
            parity_r <= parity_nxt;
        end
    end

    // ************************************************************
    // User flag register
    // ************************************************************

    // No hardware event reaches this register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            user_r <= RST_USER_FLAG;
        end else begin
            user_r <= user_nxt;
        end
    end

    // ************************************************************
    // Bank select registers
    // ************************************************************

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bsh_r <= RST_BANK;
            bsl_r <= RST_BANK;
        end else begin
            bsh_r <= bsh_nxt;
            bsl_r <= bsl_nxt;
        end
    end

    // Base kept as a register so the output is a plain flip-flop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            base_r <= RST_BANK_BASE;
        end else begin
            base_r <= base_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    assign overflow_flag = overflow_r;
    assign user_flag_one = user_r;
    assign parity_flag = parity_r;
    assign bank_select_high = bsh_r;
    assign bank_select_low = bsl_r;
    assign bank_base_addr = base_r;

endmodule : status_flag_logic

//--- status_flag_pkg.sv
// Purpose: Constants for the status-word flag logic.
// Assumes: 8-bit accumulator, four 8-byte register banks.
// Notes: Operation summary follows.
package status_flag_pkg;
    localparam int DATA_W = 8;
    localparam int BANK_ADDR_W = 5;
    localparam logic [7:0] PRODUCT_LIMIT = 8'hFF;
    localparam logic [2:0] BANK_SHIFT = 3'h3;
    localparam logic RST_OVERFLOW = 1'b0;
    localparam logic RST_USER_FLAG = 1'b0;
    localparam logic RST_BANK = 1'b0;
    localparam logic RST_PARITY = 1'b0;
    localparam logic [BANK_ADDR_W-1:0] RST_BANK_BASE = 5'h00;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ADD = 3'b001,
        OP_ADD_WITH_CARRY_OP = 3'b010,
        OP_SUBTRACT_WITH_BORROW_OP = 3'b011,
        OP_MUL = 3'b100,
        OP_DIV = 3'b101
    } alu_op_t;
endpackage : status_flag_pkg

//--- sf_asserts.sv
// Purpose: Port checks for the flag block. Assumes: one clock. Notes: bound below.
`timescale 1ns/1ps
module sf_chk import status_flag_pkg::*; (input wire logic core_clk, srst, wb_valid, sw_write,
    input wire logic sw_user_flag_one, overflow_flag, user_flag_one, parity_flag,
    input wire logic bank_select_high, bank_select_low, input wire alu_op_t wb_op,
    input wire logic [7:0] operand_a, operand_b, sum_result, accumulator,
    input wire logic [15:0] product, input wire logic [4:0] bank_base_addr);
default clocking @(posedge core_clk); endclocking
default disable iff (srst);
wire o = overflow_flag, m = wb_valid && wb_op == OP_MUL;
wire d = wb_valid && wb_op == OP_DIV, s = wb_valid && wb_op inside {OP_ADD, OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_BORROW_OP};
// Sign rule differs for subtract: operands of unlike sign
wire g = (operand_a[7] ^ operand_b[7] ^ (wb_op != OP_SUBTRACT_WITH_BORROW_OP)) & (sum_result[7] ^ operand_a[7]);
add_ovf_a: assert property (s |=> o == $past(g)) else $error("add");
mul_ovf_a: assert property (m |=> o == $past(|product[15:8])) else $error("mul");
div_ovf_a: assert property (d |=> o == $past(operand_b == 8'h00)) else $error("div");
ovf_hold_a: assert property (!(s || m || d) |=> $stable(o)) else $error("hold");
parity_a: assert property (1 |=> parity_flag == $past(^accumulator)) else $error("par");
user_hold_a: assert property (!sw_write |=> $stable(user_flag_one)) else $error("uf");
sw_load_a: assert property (sw_write |=> user_flag_one == $past(sw_user_flag_one))
    else $error("sw");
bank_map_a: assert property (bank_base_addr == {bank_select_high, bank_select_low, 3'h0})
    else $error("bank");
endmodule : sf_chk
bind status_flag_logic sf_chk chk_u (.*);

//--- alu_model.sv
// Purpose: ALU result model. Assumes: carry folded in. Notes: no flags.
`timescale 1ns/1ps
module alu_model import status_flag_pkg::*; (input wire alu_op_t wb_op, input wire logic cin,
    input wire logic [7:0] operand_a, operand_b, output logic [7:0] sum_result,
    output logic [15:0] product);
// Bench keeps cin low except for carry and borrow ops
assign sum_result = wb_op == OP_SUBTRACT_WITH_BORROW_OP ? operand_a - operand_b - cin : operand_a + operand_b + cin;
assign product = operand_a * operand_b;
endmodule : alu_model

//--- testbench.sv
// Purpose: Flag bench. Assumes: alu_model. Notes: no random stimulus.
`timescale 1ns/1ps
module testbench import status_flag_pkg::*;;
logic core_clk = 0, srst = 1, wb_valid = 0, cin = 0, sw_write = 0, sw_user_flag_one = 0;
logic sw_bank_select_high = 0, sw_bank_select_low = 0, overflow_flag, user_flag_one, parity_flag;
logic bank_select_high, bank_select_low;
logic [7:0] operand_a = 0, operand_b = 0, accumulator = 0, sum_result;
logic [15:0] product;
logic [4:0] bank_base_addr;
alu_op_t wb_op = OP_NONE;
int fails = 0, num_checks = 0;
always #50 core_clk = ~core_clk;
alu_model alu_u (.*);
status_flag_logic dut_u (.*);
task chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
        fails++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
endtask : chk
task stop_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask : stop_test
task op(input alu_op_t o, input logic [7:0] a, b, input logic c, e);
    @(posedge core_clk) {wb_valid, wb_op, operand_a, operand_b, cin} <= {1'h1, o, a, b, c};
    @(posedge core_clk) wb_valid <= 1'h0;
    #1 chk(overflow_flag, e);
endtask : op
task t_ovf;
    op(OP_ADD, 8'h7F, 8'h01, 1'h0, 1'h1);
    op(OP_ADD_WITH_CARRY_OP, 8'h7F, 8'h00, 1'h1, 1'h1);
    op(OP_SUBTRACT_WITH_BORROW_OP, 8'h80, 8'h01, 1'h0, 1'h1);
    op(OP_MUL, 8'h0F, 8'h11, 1'h0, 1'h0);
    op(OP_MUL, 8'h10, 8'h10, 1'h0, 1'h1);
    op(OP_ADD, 8'h01, 8'h01, 1'h0, 1'h0);
    op(OP_DIV, 8'h05, 8'h00, 1'h0, 1'h1);
    op(OP_NONE, 8'h05, 8'h01, 1'h0, 1'h1);
    op(OP_DIV, 8'h05, 8'h01, 1'h0, 1'h0);
endtask : t_ovf
task t_idle;
    @(posedge core_clk) {wb_op, operand_a, operand_b} <= {OP_DIV, 8'h05, 8'h00};
    @(posedge core_clk);
    #1 chk(overflow_flag, 1'h0);
endtask : t_idle
task t_reset;
    op(OP_DIV, 8'h01, 8'h00, 1'h0, 1'h1);
    @(posedge core_clk) srst <= 1'h1;
    @(posedge core_clk) srst <= 1'h0;
    #1 chk(overflow_flag, RST_OVERFLOW);
    chk(parity_flag, RST_PARITY);
    chk(user_flag_one, RST_USER_FLAG);
    chk(bank_base_addr, 8'h00);
    chk(bank_select_high, RST_BANK);
    op(OP_ADD, 8'h7F, 8'h01, 1'h0, 1'h1);
    chk(parity_flag, ^accumulator);
endtask : t_reset
task t_sw_par;
    for (int i = 0; i < 4; i++) begin
        @(posedge core_clk) {sw_write, sw_bank_select_high, sw_bank_select_low} <= {1'h1, i[1:0]};
        sw_user_flag_one <= ~i[0];
        accumulator <= 8'h5A >> i;
        @(posedge core_clk) sw_write <= 1'h0;
        #1 chk(bank_base_addr, 8'(i * 8));
        chk(user_flag_one, !i[0]);
        chk(bank_select_high, i[1]);
        chk(bank_select_low, i[0]);
        chk(parity_flag, ^(8'h5A >> i));
    end
endtask : t_sw_par
initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'h0;
    t_ovf;
    t_idle;
    t_sw_par;
    t_reset;
    stop_test;
end
// Run needs about 40 cycles; the limit leaves wide margin
initial begin
    #100000;
    fails++;
    stop_test;
end
endmodule : testbench
